// *** logic/aro_params.svh ***
// constants for the converter result output port
// assumes a 250 MHz system clock; included by the port module only
`ifndef ARO_PARAMS_SVH
`define ARO_PARAMS_SVH
`define ARO_RES_W        16
`define ARO_BYTE_W       8
`define ARO_SER_BITS     16
`define ARO_CLK_MHZ      250
`define ARO_CONV_NS      20000
`define ARO_CONV_CYC     ((`ARO_CONV_NS * `ARO_CLK_MHZ) / 1000)
`define ARO_HALF_NS      32
`define ARO_HALF_CYC     ((`ARO_HALF_NS * `ARO_CLK_MHZ) / 1000)
`define ARO_FIFO_DEPTH   16
`endif

// *** logic/aro_pkg.sv ***
// types for the converter result output port
// assumes aro_params.svh sits on the include path
package aro_pkg;
	typedef enum logic [1:0] {
		ARO_IDLE = 2'b00,
		ARO_CONV = 2'b01,
		ARO_DONE = 2'b10
	} aro_conv_t;
	typedef enum logic [1:0] {
		ARO_SIDLE = 2'b00,
		ARO_SHIGH = 2'b01,
		ARO_SLOW  = 2'b10
	} aro_ser_t;
endpackage

// *** logic/aro_fifo.sv ***
// result fifo between the converter core and the output register
// assumes one clock; source honours in_ready
`timescale 1ns/1ps
module aro_fifo
	import aro_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
		logic          rdy;
	} aro_fifo_t;
	aro_fifo_t s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign in_ready  = s_q.rdy;
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = mem[s_q.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_d = s_q;
		if (push)
			s_d.wr = s_q.wr + 1'b1;
		if (pop)
			s_d.rd = s_q.rd + 1'b1;
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		// ready from a flop so the core never sees a combinational path
		s_d.rdy = (s_d.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[s_q.wr] <= in_data;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	a_fifo_no_over: assert property (@(posedge clk) disable iff (rst)
		s_q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// *** logic/aro_sync.sv ***
// three-stage synchroniser for pin inputs
// assumes inputs are asynchronous to clk; change counts when stages two and three agree
`timescale 1ns/1ps
module aro_sync
	import aro_pkg::*;
#(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// pins and filtered levels
	input  wire logic [W-1:0] pin,
	output logic [W-1:0]      level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lv;
	} aro_sync_t;
	aro_sync_t s_q, s_d;

	assign level = s_q.lv;

	always_comb begin
		s_d    = s_q;
		s_d.s1 = pin;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		for (int i = 0; i < W; i++) begin
			if (s_q.s2[i] == s_q.s3[i])
				s_d.lv[i] = s_q.s3[i];
		end
	end

	// idle levels: select high, read high, so nothing converts out of reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_q <= '1;
		else
			s_q <= s_d;
	end
endmodule

// *** logic/aro_port.sv ***
// result output port: parallel byte bus, serial stream, busy and conversion start
// assumes the converter core hands in raw offset-binary results with a valid strobe
`timescale 1ns/1ps
`include "aro_params.svh"
module aro_port
	import aro_pkg::*;
#(
	parameter int RES_W    = `ARO_RES_W,
	parameter int CONV_CYC = `ARO_CONV_CYC,
	parameter int HALF_CYC = `ARO_HALF_CYC,
	parameter int DEPTH    = `ARO_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             CLK_SYS,
	input  wire logic             RST,
	// host control pins
	input  wire logic             CHIP_SELECT_N,
	input  wire logic             READ_CONVERT,
	input  wire logic             BYTE_HALF_SELECT,
	input  wire logic             OUTPUT_CODING_SELECT,
	input  wire logic             SERIAL_CLOCK_SOURCE_SELECT,
	// converter core
	input  wire logic [RES_W-1:0] CORE_RESULT,
	input  wire logic             CORE_VALID,
	output logic                  CORE_READY,
	output logic                  CORE_START,
	// parallel bus
	output logic [7:0]            PARALLEL_DATA_O,
	output logic                  PARALLEL_DATA_OE,
	// serial link
	input  wire logic             SERIAL_DATA_CLOCK_I,
	output logic                  SERIAL_DATA_CLOCK_O,
	output logic                  SERIAL_DATA_CLOCK_OE,
	output logic                  SERIAL_DATA,
	// status
	output logic                  BUSY_N
);
	localparam int CW = $clog2(CONV_CYC + 1);
	localparam int HW = $clog2(HALF_CYC + 1);

	typedef struct packed {
		aro_conv_t        cst;
		logic [CW-1:0]    ccnt;
		logic             start;
		logic             busy_n;
		logic             conv_l;
		logic [RES_W-1:0] res;
		logic [RES_W-1:0] shf;
		aro_ser_t         sst;
		logic [4:0]       bits;
		logic [4:0]       pcnt;
		logic [HW-1:0]    hcnt;
		logic             sclk;
		logic             sclk_oe;
		logic             sdat;
		logic             eclk_l;
		logic             ext_act;
		logic [7:0]       pd;
		logic             poe;
	} aro_port_t;
	aro_port_t s_q, s_d;

	logic             cs_n, rdc, bsel, code_sb, ext_mode, eclk;
	logic             conv_now, eclk_fall;
	logic             f_valid, f_ready;
	logic [RES_W-1:0] f_data, coded;

	aro_sync #(
		.W(6)
	) u_sync (
		.clk   (CLK_SYS),
		.rst   (RST),
		.pin   ({CHIP_SELECT_N, READ_CONVERT, BYTE_HALF_SELECT,
		         OUTPUT_CODING_SELECT, SERIAL_CLOCK_SOURCE_SELECT, SERIAL_DATA_CLOCK_I}),
		.level ({cs_n, rdc, bsel, code_sb, ext_mode, eclk})
	);

	// core results queue here; core stalls via CORE_READY when full
	aro_fifo #(
		.WIDTH(RES_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk       (CLK_SYS),
		.rst       (RST),
		.in_valid  (CORE_VALID),
		.in_ready  (f_ready),
		.in_data   (CORE_RESULT),
		.out_valid (f_valid),
		.out_ready (s_q.cst == ARO_DONE),
		.out_data  (f_data)
	);

	// or of select and read/convert: a fall of the or starts a conversion
	assign conv_now  = s_q.conv_l && !(cs_n || rdc);
	assign eclk_fall = s_q.eclk_l && !eclk;
	// twos complement flips the msb of the offset-binary core code
	assign coded = code_sb ? f_data : {~f_data[RES_W-1], f_data[RES_W-2:0]};

	assign CORE_READY           = f_ready;
	assign CORE_START           = s_q.start;
	assign PARALLEL_DATA_O      = s_q.pd;
	assign PARALLEL_DATA_OE     = s_q.poe;
	assign SERIAL_DATA_CLOCK_O  = s_q.sclk;
	assign SERIAL_DATA_CLOCK_OE = s_q.sclk_oe;
	assign SERIAL_DATA          = s_q.sdat;
	assign BUSY_N               = s_q.busy_n;

	always_comb begin
		s_d        = s_q;
		s_d.start  = 1'b0;
		s_d.conv_l = cs_n || rdc;
		s_d.eclk_l = eclk;
		// conversion sequencer; a new start while busy is ignored
		unique case (s_q.cst)
			ARO_IDLE: begin
				if (conv_now) begin
					s_d.cst    = ARO_CONV;
					s_d.ccnt   = '0;
					s_d.start  = 1'b1;
					s_d.busy_n = 1'b0;
					s_d.shf    = s_q.res;
					s_d.bits   = 5'(`ARO_SER_BITS);
					s_d.ext_act = ext_mode;
					if (!ext_mode) begin
						s_d.sst  = ARO_SHIGH;
						s_d.pcnt = '0;
						s_d.hcnt = '0;
						s_d.sdat = s_q.res[RES_W-1];
					end
				end
			end
			ARO_CONV: begin
				if (s_q.ccnt >= CW'(CONV_CYC - 1))
					s_d.cst = ARO_DONE;
				else
					s_d.ccnt = s_q.ccnt + 1'b1;
			end
			ARO_DONE: begin
				// wait for the core result, then update and release busy
				if (f_valid) begin
					s_d.res    = coded;
					s_d.busy_n = 1'b1;
					s_d.cst    = ARO_IDLE;
				end
			end
			default: s_d.cst = ARO_IDLE;
		endcase
		// internal clock: 16 pulses, idle low
		unique case (s_q.sst)
			ARO_SIDLE: begin
				s_d.sclk    = 1'b0;
				s_d.sclk_oe = !ext_mode;
			end
			ARO_SHIGH: begin
				if (s_q.hcnt >= HW'(HALF_CYC - 1)) begin
					s_d.hcnt = '0;
					s_d.sclk = 1'b1;
					s_d.sst  = ARO_SLOW;
					s_d.pcnt = s_q.pcnt + 1'b1;
				end else
					s_d.hcnt = s_q.hcnt + 1'b1;
			end
			ARO_SLOW: begin
				if (s_q.hcnt >= HW'(HALF_CYC - 1)) begin
					s_d.hcnt = '0;
					s_d.sclk = 1'b0;
					s_d.shf  = {s_q.shf[RES_W-2:0], 1'b0};
					s_d.bits = s_q.bits - 1'b1;
					if (s_q.bits == 5'd1)
						s_d.sst = ARO_SIDLE;
					else
						s_d.sst = ARO_SHIGH;
					s_d.sdat = s_q.shf[RES_W-2];
				end else
					s_d.hcnt = s_q.hcnt + 1'b1;
			end
			default: s_d.sst = ARO_SIDLE;
		endcase
		// external clock: load on select, shift on each host clock fall
		if (s_q.sst == ARO_SIDLE && ext_mode) begin
			if (!cs_n && rdc && s_q.cst == ARO_IDLE && !s_q.ext_act) begin
				s_d.shf     = s_q.res;
				s_d.bits    = 5'(`ARO_SER_BITS);
				s_d.ext_act = 1'b1;
				s_d.sdat    = s_q.res[RES_W-1];
			end else if (s_q.ext_act && eclk_fall && s_q.bits != '0) begin
				s_d.shf  = {s_q.shf[RES_W-2:0], 1'b0};
				s_d.sdat = s_q.shf[RES_W-2];
				s_d.bits = s_q.bits - 1'b1;
			end
			if (cs_n)
				s_d.ext_act = 1'b0;
		end
		// parallel bus: msb byte when low, lsb byte when high
		s_d.pd  = bsel ? s_q.res[7:0] : s_q.res[15:8];
		s_d.poe = !cs_n && rdc;
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			s_q        <= '0;
			s_q.cst    <= ARO_IDLE;
			s_q.sst    <= ARO_SIDLE;
			s_q.busy_n <= 1'b1;
			s_q.conv_l <= 1'b1;
		end else
			s_q <= s_d;
	end

	a_busy_on_start: assert property (@(posedge CLK_SYS) disable iff (RST)
		conv_now && s_q.cst == ARO_IDLE |=> !BUSY_N && CORE_START)
		else $error("busy not low after start");
	a_drive_when_read: assert property (@(posedge CLK_SYS) disable iff (RST)
		PARALLEL_DATA_OE |-> $past(!cs_n && rdc))
		else $error("bus driven while not read");
	a_byte_low_half: assert property (@(posedge CLK_SYS) disable iff (RST)
		$past(bsel) && $stable(s_q.res) |-> PARALLEL_DATA_O == s_q.res[7:0])
		else $error("low byte wrong");
	a_byte_high_half: assert property (@(posedge CLK_SYS) disable iff (RST)
		!$past(bsel) && $stable(s_q.res) |-> PARALLEL_DATA_O == s_q.res[15:8])
		else $error("high byte wrong");
	a_clock_idle_low: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.sst == ARO_SIDLE && $past(s_q.sst) == ARO_SIDLE |-> !SERIAL_DATA_CLOCK_O)
		else $error("serial clock not low when idle");
	a_result_stable: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.cst != ARO_DONE |=> $stable(s_q.res))
		else $error("result changed outside update");
	a_busy_release: assert property (@(posedge CLK_SYS) disable iff (RST)
		$rose(BUSY_N) |-> $past(s_q.cst) == ARO_DONE)
		else $error("busy released early");
	a_coding_msb: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.cst == ARO_DONE && f_valid && !code_sb |=> s_q.res[15] != $past(f_data[15]))
		else $error("twos complement msb not inverted");
	a_ext_no_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
		$past(ext_mode) && s_q.sst == ARO_SIDLE |-> !SERIAL_DATA_CLOCK_OE)
		else $error("clock driven in external mode");
	a_sixteen_count: assert property (@(posedge CLK_SYS) disable iff (RST)
		conv_now && s_q.cst == ARO_IDLE && !ext_mode |=> s_q.bits == 5'd16)
		else $error("burst not sixteen bits");
	a_oe_off_deselect: assert property (@(posedge CLK_SYS) disable iff (RST)
		$past(cs_n) |-> !PARALLEL_DATA_OE)
		else $error("bus driven while deselected");
	a_oe_off_convert: assert property (@(posedge CLK_SYS) disable iff (RST)
		!$past(rdc) |-> !PARALLEL_DATA_OE)
		else $error("bus driven while converting");
	a_oe_on_read: assert property (@(posedge CLK_SYS) disable iff (RST)
		$past(!cs_n && rdc) |-> PARALLEL_DATA_OE)
		else $error("bus not driven while read");
	a_start_one_cycle: assert property (@(posedge CLK_SYS) disable iff (RST)
		CORE_START |=> !CORE_START)
		else $error("start pulse too long");
	a_start_on_fall: assert property (@(posedge CLK_SYS) disable iff (RST)
		CORE_START |-> $past(conv_now) && $past(s_q.cst) == ARO_IDLE)
		else $error("start without convert fall");
	a_busy_in_conv: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.cst == ARO_CONV |-> !BUSY_N)
		else $error("busy high while converting");
	a_busy_in_done: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.cst == ARO_DONE |-> !BUSY_N)
		else $error("busy high before update");
	a_busy_high_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.cst == ARO_IDLE |-> BUSY_N)
		else $error("busy low while idle");
	a_update_release: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.cst == ARO_DONE && f_valid |=> BUSY_N && s_q.res == $past(coded))
		else $error("result not updated with busy release");
	a_coding_straight: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.cst == ARO_DONE && f_valid && code_sb |=> s_q.res == $past(f_data))
		else $error("straight binary result altered");
	a_coding_low_bits: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.cst == ARO_DONE && f_valid && !code_sb
		|=> s_q.res[RES_W-2:0] == $past(f_data[RES_W-2:0]))
		else $error("twos complement low bits altered");
	a_res_only_done: assert property (@(posedge CLK_SYS) disable iff (RST)
		$changed(s_q.res) |-> $past(s_q.cst) == ARO_DONE)
		else $error("result changed without conversion end");
	// serial guards; a start inside a running burst is out of order and not covered
	a_int_drives_clock: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.sst != ARO_SIDLE |-> SERIAL_DATA_CLOCK_OE)
		else $error("burst without clock drive");
	a_int_idle_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
		!$past(ext_mode) && s_q.sst == ARO_SIDLE && $past(s_q.sst) == ARO_SIDLE
		|-> SERIAL_DATA_CLOCK_OE)
		else $error("internal clock pin not driven");
	a_first_bit_msb: assert property (@(posedge CLK_SYS) disable iff (RST)
		conv_now && s_q.cst == ARO_IDLE && !ext_mode && s_q.sst == ARO_SIDLE
		|=> SERIAL_DATA == $past(s_q.res[RES_W-1]))
		else $error("burst does not open with msb");
	a_rise_in_burst: assert property (@(posedge CLK_SYS) disable iff (RST)
		$rose(SERIAL_DATA_CLOCK_O) |-> s_q.sst == ARO_SLOW)
		else $error("clock pulse outside burst");
	a_fall_on_shift: assert property (@(posedge CLK_SYS) disable iff (RST)
		$fell(SERIAL_DATA_CLOCK_O) |-> $past(s_q.sst) == ARO_SLOW)
		else $error("clock fall outside burst");
	a_pulse_total: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.sst == ARO_SLOW && s_q.bits == 5'd1 && s_q.hcnt >= HW'(HALF_CYC - 1)
		|-> s_q.pcnt == 5'(`ARO_SER_BITS))
		else $error("burst pulse count not sixteen");
	a_burst_ends_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.sst == ARO_SLOW && s_q.bits == 5'd1 && s_q.hcnt >= HW'(HALF_CYC - 1)
		|=> s_q.sst == ARO_SIDLE && !SERIAL_DATA_CLOCK_O)
		else $error("clock not idle after last pulse");
	a_data_on_fall: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.sst == ARO_SLOW |=> $stable(SERIAL_DATA) || $fell(SERIAL_DATA_CLOCK_O))
		else $error("serial data moved off a clock fall");
	a_ext_shift_fall: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.sst == ARO_SIDLE && ext_mode && s_q.ext_act && eclk_fall && s_q.bits != '0
		|=> SERIAL_DATA == $past(s_q.shf[RES_W-2]))
		else $error("host clock fall did not shift");
	a_ext_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
		s_q.sst == ARO_SIDLE && ext_mode && s_q.ext_act && !eclk_fall
		|=> $stable(SERIAL_DATA))
		else $error("serial data moved without host clock");
endmodule

// *** tb/aro_host_model.sv ***
// host side model: external data clock source and resolved pad levels
// assumes burst() is called only with external clock mode selected
`timescale 1ns/1ps
module aro_host_model (
	// device pins
	input  wire logic [7:0] dev_byte,
	input  wire logic       dev_oe,
	input  wire logic       dev_sck,
	input  wire logic       dev_sck_oe,
	input  wire logic       dev_sdata,
	// resolved levels
	output logic [7:0]      pad,
	output logic            sck_pin
);
	logic        sck_h = 1'b0;
	logic [7:0]  last = 8'h00;
	logic [15:0] got = 16'h0000;
	always @(dev_byte, dev_oe) if (dev_oe) last = dev_byte;
	// released bus shows the inverse, so a stale byte never passes
	assign pad = dev_oe ? dev_byte : ~last;
	// clock stands low outside a frame
	assign sck_pin = dev_sck_oe ? dev_sck : sck_h;
	task automatic burst();
		for (int i = 0; i < 16; i++) begin
			#32 sck_h = 1'b1;
			got = {got[14:0], dev_sdata};
			#32 sck_h = 1'b0;
		end
	endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the result output port
// assumes design files and the host model are compiled first
`timescale 1ns/1ps
module testbench
	import aro_pkg::*;
;
	localparam int CONV = 20;
	logic clk = 1'b0, rst = 1'b1, cs_n = 1'b1, rdc = 1'b1;
	logic byte_sel = 1'b0, cod = 1'b1, ext = 1'b0, core_v = 1'b0;
	logic [15:0] core_d = 16'h0000;
	logic core_rdy, oe, sck_o, sck_oe, sdata, busy_n, sck_pin, sck_q, start;
	logic [7:0] d_o, pad;
	logic [31:0] lfsr = 32'h83268D5C;
	logic [15:0] exp_q[$];
	logic [15:0] cur, prev, w, ser;
	int miscompares = 0, compares = 0, pulses, n;

	aro_port #(.CONV_CYC(CONV)) i_dut (.CLK_SYS(clk), .RST(rst), .CHIP_SELECT_N(cs_n),
		.READ_CONVERT(rdc), .BYTE_HALF_SELECT(byte_sel), .OUTPUT_CODING_SELECT(cod),
		.SERIAL_CLOCK_SOURCE_SELECT(ext), .CORE_RESULT(core_d), .CORE_VALID(core_v),
		.CORE_READY(core_rdy), .CORE_START(start), .PARALLEL_DATA_O(d_o),
		.PARALLEL_DATA_OE(oe), .SERIAL_DATA_CLOCK_I(sck_pin), .SERIAL_DATA_CLOCK_O(sck_o),
		.SERIAL_DATA_CLOCK_OE(sck_oe), .SERIAL_DATA(sdata), .BUSY_N(busy_n));
	aro_host_model i_host (.dev_byte(d_o), .dev_oe(oe), .dev_sck(sck_o),
		.dev_sck_oe(sck_oe), .dev_sdata(sdata), .pad(pad), .sck_pin(sck_pin));

	initial forever #2 clk = ~clk;

	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// offset binary core word; twos complement flips the msb
	function automatic logic [15:0] coded(input logic [15:0] v, input logic c);
		return c ? v : v ^ 16'h8000;
	endfunction
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// internal burst capture on the device clock's rising edges
	always @(posedge clk) begin
		sck_q <= sck_o;
		if (sck_o && !sck_q) begin
			pulses <= pulses + 1;
			ser <= {ser[14:0], sdata};
		end
	end

	task automatic conv();
		pulses = 0;
		@(negedge clk) rdc = 1'b0;
		n = 0;
		while (busy_n !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("busy start", 16'h0, {15'h0, busy_n});
		chk("start pulse", 16'h1, {15'h0, start});
		chk("oe converting", 16'h0, {15'h0, oe});
		n = 0;
		while (busy_n !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		chk("busy span", 16'h1, {15'h0, n >= CONV - 1 && n <= CONV + 4});
		rdc = 1'b1;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		repeat (6) @(negedge clk);
		chk("oe deselected", 16'h0, {15'h0, oe});
		repeat (20) begin
			lfsr = step(lfsr);
			core_d = lfsr[15:0];
			core_v = 1'b1;
			// ready is settled here and is what the next rising edge takes
			if (core_rdy === 1'b1) exp_q.push_back(core_d);
			@(negedge clk);
		end
		core_v = 1'b0;
		chk("fifo fill", 16'd16, 16'(exp_q.size()));
		chk("fifo full", 16'h0, {15'h0, core_rdy});
		cs_n = 1'b0;
		for (int k = 0; k < 16; k++) begin
			lfsr = step(lfsr);
			ext = lfsr[0];
			// coding only moves on external runs so a burst's word keeps its coding
			if (ext) cod = lfsr[1];
			cur = exp_q.pop_front();
			w = coded(cur, cod);
			conv();
			for (int b = 0; b < 2; b++) begin
				byte_sel = b[0];
				repeat (8) @(negedge clk);
				chk("parallel", {8'h00, b ? w[7:0] : w[15:8]}, {8'h00, pad});
			end
			if (ext) begin
				cs_n = 1'b1;
				repeat (8) @(negedge clk);
				chk("oe released", 16'h0, {15'h0, oe});
				cs_n = 1'b0;
				repeat (8) @(negedge clk);
				i_host.burst();
				chk("serial ext", w, i_host.got);
			end else begin
				repeat (300) @(negedge clk);
				if (k > 0) chk("serial int", coded(prev, cod), ser);
				chk("pulses", 16'd16, 16'(pulses));
				chk("clock idle", 16'h0, {15'h0, sck_o});
			end
			prev = cur;
		end
		chk("fifo drained", 16'h1, {15'h0, core_rdy});
		close_out();
	end

	initial begin
		#200000;
		miscompares++;
		close_out();
	end
endmodule
